// ---- hw/byte_buffer.sv ----
// Two-entry valid/ready buffer for the outgoing byte stream
`timescale 1ns/1ps
module byte_buffer (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [frame_check_pkg::BUF_WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [frame_check_pkg::BUF_WIDTH-1:0] out_data
);
    logic [frame_check_pkg::BUF_WIDTH-1:0] mem_r [frame_check_pkg::BUF_DEPTH];
    logic [frame_check_pkg::BUF_WIDTH-1:0] mem_nxt [frame_check_pkg::BUF_DEPTH];
    logic wr_r, wr_nxt, rd_r, rd_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        for (int i = 0; i < frame_check_pkg::BUF_DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wr_r] = in_data;
            wr_nxt = ~wr_r;
        end
        if (pop) begin
            rd_nxt = ~rd_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < frame_check_pkg::BUF_DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule // byte_buffer

// ---- hw/frame_check_pkg.sv ----
// Constants shared by the serial frame check logic
package frame_check_pkg;
    localparam logic [15:0] CRC_PRESET = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam int CRC_SHIFTS = 8;
    localparam logic [7:0] LRC_CLEAR = 8'h00;
    localparam logic [7:0] LRC_ONES = 8'hff;
    localparam logic [7:0] LRC_ONE = 8'h01;
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_NINE = 8'h39;
    localparam logic [7:0] CHAR_UPPER_A = 8'h41;
    localparam logic [7:0] CHAR_UPPER_F = 8'h46;
    localparam logic [7:0] DIGIT_LIMIT = 8'h0a;
    localparam logic [1:0] RX_MIN_TAIL = 2'h2;
    localparam logic [7:0] FUNC_REPORT_ID = 8'h11;
    localparam int ID_REQ_BYTES = 4;
    localparam int ID_BYTE_COUNT = 26;
    localparam int ID_NAME_BYTES = 20;
    localparam int ID_FIELD_BYTES = 2;
    localparam int BUF_WIDTH = 8;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [2:0] {
        TX_MSG = 3'b001,
        TX_CK1 = 3'b010,
        TX_CK2 = 3'b100
    } tx_state_t;
endpackage

// ---- hw/modbus_crc_lrc_checker.sv ----
// Modbus frame check generation (transmit) and verification (receive)
`timescale 1ns/1ps
module modbus_crc_lrc_checker (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic ASCII_MODE,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_SOF,
    input wire logic RX_EOF,
    output logic RX_DONE,
    output logic RX_ERR,
    input wire logic MSG_VALID,
    input wire logic [7:0] MSG_DATA,
    input wire logic MSG_SOF,
    input wire logic MSG_LAST,
    output logic MSG_READY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY
);
    // One byte through eight bit-serial shift steps
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = {crc[15:8], crc[7:0] ^ b};
        for (int i = 0; i < frame_check_pkg::CRC_SHIFTS; i++) begin
            if (c[0]) begin
                c = {1'b0, c[15:1]} ^ frame_check_pkg::CRC_POLY;
            end else begin
                c = {1'b0, c[15:1]};
            end
        end
        return c;
    endfunction

    function automatic logic [7:0] lrc_final(input logic [7:0] sum);
        return (frame_check_pkg::LRC_ONES - sum) + frame_check_pkg::LRC_ONE;
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        logic [7:0] w;
        w = {4'h0, n};
        if (w < frame_check_pkg::DIGIT_LIMIT) begin
            return frame_check_pkg::CHAR_ZERO + w;
        end
        return frame_check_pkg::CHAR_UPPER_A + (w - frame_check_pkg::DIGIT_LIMIT);
    endfunction

    // Bit 4 set means the character is not an uppercase hex digit (0-9, A-F)
    function automatic logic [4:0] hex_value(input logic [7:0] c);
        if (c >= frame_check_pkg::CHAR_ZERO && c <= frame_check_pkg::CHAR_NINE) begin
            return {1'b0, 4'(c - frame_check_pkg::CHAR_ZERO)};
        end
        if (c >= frame_check_pkg::CHAR_UPPER_A && c <= frame_check_pkg::CHAR_UPPER_F) begin
            return {1'b0, 4'(c - frame_check_pkg::CHAR_UPPER_A + frame_check_pkg::DIGIT_LIMIT)};
        end
        return 5'h10;
    endfunction

    // Receive side: the last two bytes of a frame are the check field, so every byte
    // is held back two places before it joins the accumulators.
    logic [15:0] rx_crc_r, rx_crc_nxt;
    logic [7:0] rx_sum_r, rx_sum_nxt;
    logic [7:0] rx_old_r, rx_old_nxt, rx_new_r, rx_new_nxt;
    logic [1:0] rx_cnt_r, rx_cnt_nxt;
    logic rx_done_r, rx_done_nxt, rx_err_r, rx_err_nxt;

    always_comb begin
        logic [15:0] crc_cur;
        logic [7:0] sum_cur;
        logic [4:0] hi_nib, lo_nib;
        logic [1:0] cnt_cur;
        crc_cur = rx_crc_r;
        sum_cur = rx_sum_r;
        cnt_cur = rx_cnt_r;
        hi_nib = 5'h0;
        lo_nib = 5'h0;
        rx_crc_nxt = rx_crc_r;
        rx_sum_nxt = rx_sum_r;
        rx_old_nxt = rx_old_r;
        rx_new_nxt = rx_new_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_done_nxt = 1'b0;
        rx_err_nxt = 1'b0;
        if (RX_VALID) begin
            if (RX_SOF) begin
                crc_cur = frame_check_pkg::CRC_PRESET;
                sum_cur = frame_check_pkg::LRC_CLEAR;
                cnt_cur = 2'h0;
            end
            if (cnt_cur == frame_check_pkg::RX_MIN_TAIL) begin
                crc_cur = crc_byte(crc_cur, rx_old_r);
                sum_cur = sum_cur + rx_old_r;
            end else begin
                cnt_cur = cnt_cur + 2'h1;
            end
            rx_old_nxt = rx_new_r;
            rx_new_nxt = RX_DATA;
            if (RX_EOF) begin
                rx_done_nxt = 1'b1;
                hi_nib = hex_value(rx_new_r);
                lo_nib = hex_value(RX_DATA);
                if (cnt_cur != frame_check_pkg::RX_MIN_TAIL) begin
                    rx_err_nxt = 1'b1;
                end else if (ASCII_MODE) begin
                    rx_err_nxt = hi_nib[4] || lo_nib[4] ||
                        ({hi_nib[3:0], lo_nib[3:0]} != lrc_final(sum_cur));
                end else begin
                    rx_err_nxt = ({RX_DATA, rx_new_r} != crc_cur);
                end
                cnt_cur = 2'h0;
            end
            rx_crc_nxt = crc_cur;
            rx_sum_nxt = sum_cur;
            rx_cnt_nxt = cnt_cur;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rx_crc_r <= frame_check_pkg::CRC_PRESET;
            rx_sum_r <= frame_check_pkg::LRC_CLEAR;
            rx_old_r <= 8'h00;
            rx_new_r <= 8'h00;
            rx_cnt_r <= 2'h0;
            rx_done_r <= 1'b0;
            rx_err_r <= 1'b0;
        end else begin
            rx_crc_r <= rx_crc_nxt;
            rx_sum_r <= rx_sum_nxt;
            rx_old_r <= rx_old_nxt;
            rx_new_r <= rx_new_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_done_r <= rx_done_nxt;
            rx_err_r <= rx_err_nxt;
        end
    end

    assign RX_DONE = rx_done_r;
    assign RX_ERR = rx_err_r;

    // Transmit side: message bytes pass straight to the buffer, then two check items follow
    frame_check_pkg::tx_state_t tx_state_r, tx_state_nxt;
    logic [15:0] tx_crc_r, tx_crc_nxt;
    logic [7:0] tx_sum_r, tx_sum_nxt;
    logic tx_ascii_r, tx_ascii_nxt;
    logic buf_valid, buf_ready;
    logic [7:0] buf_data;
    logic [7:0] lrc_val;

    assign lrc_val = lrc_final(tx_sum_r);

    always_comb begin
        logic [15:0] crc_cur;
        logic [7:0] sum_cur;
        crc_cur = tx_crc_r;
        sum_cur = tx_sum_r;
        tx_state_nxt = tx_state_r;
        tx_crc_nxt = tx_crc_r;
        tx_sum_nxt = tx_sum_r;
        tx_ascii_nxt = tx_ascii_r;
        buf_valid = 1'b0;
        buf_data = 8'h00;
        MSG_READY = 1'b0;
        case (tx_state_r)
            frame_check_pkg::TX_MSG: begin
                MSG_READY = buf_ready;
                buf_valid = MSG_VALID;
                buf_data = MSG_DATA;
                if (MSG_VALID && buf_ready) begin
                    if (MSG_SOF) begin
                        crc_cur = frame_check_pkg::CRC_PRESET;
                        sum_cur = frame_check_pkg::LRC_CLEAR;
                        tx_ascii_nxt = ASCII_MODE;
                    end
                    tx_crc_nxt = crc_byte(crc_cur, MSG_DATA);
                    tx_sum_nxt = sum_cur + MSG_DATA;
                    if (MSG_LAST) begin
                        tx_state_nxt = frame_check_pkg::TX_CK1;
                    end
                end
            end
            frame_check_pkg::TX_CK1: begin
                buf_valid = 1'b1;
                buf_data = tx_ascii_r ? hex_char(lrc_val[7:4]) : tx_crc_r[7:0];
                if (buf_ready) begin
                    tx_state_nxt = frame_check_pkg::TX_CK2;
                end
            end
            frame_check_pkg::TX_CK2: begin
                buf_valid = 1'b1;
                buf_data = tx_ascii_r ? hex_char(lrc_val[3:0]) : tx_crc_r[15:8];
                if (buf_ready) begin
                    tx_state_nxt = frame_check_pkg::TX_MSG;
                end
            end
            default: begin
                tx_state_nxt = frame_check_pkg::TX_MSG;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tx_state_r <= frame_check_pkg::TX_MSG;
            tx_crc_r <= frame_check_pkg::CRC_PRESET;
            tx_sum_r <= frame_check_pkg::LRC_CLEAR;
            tx_ascii_r <= 1'b0;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_crc_r <= tx_crc_nxt;
            tx_sum_r <= tx_sum_nxt;
            tx_ascii_r <= tx_ascii_nxt;
        end
    end

    // Absorbs a line-side stall so no check byte is dropped
    byte_buffer u_tx_buf (
        .clk(SYS_CLK),
        .rst(RST),
        .in_valid(buf_valid),
        .in_ready(buf_ready),
        .in_data(buf_data),
        .out_valid(TX_VALID),
        .out_ready(TX_READY),
        .out_data(TX_DATA)
    );
endmodule // modbus_crc_lrc_checker

// ---- test/frame_check_assertions.sv ----
// Port-level checks for the frame check block
`timescale 1ns/1ps
module frame_check_assertions (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic RX_VALID,
    input wire logic RX_EOF,
    input wire logic RX_DONE,
    input wire logic RX_ERR,
    input wire logic MSG_VALID,
    input wire logic [7:0] MSG_DATA,
    input wire logic MSG_LAST,
    input wire logic MSG_READY,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_READY
);
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_done_after_eof: assert property (RX_VALID && RX_EOF |=> RX_DONE)
        else $error("no done");
    a_done_has_cause: assert property (RX_DONE |-> $past(RX_VALID && RX_EOF))
        else $error("stray done");
    a_err_with_done: assert property (RX_ERR |-> RX_DONE)
        else $error("lone err");
    a_done_one_cycle: assert property (RX_DONE |=> !RX_DONE)
        else $error("long done");
    a_tx_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("tx dropped");
    a_check_gap: assert property (MSG_VALID && MSG_READY && MSG_LAST |=> !MSG_READY [*2])
        else $error("no check gap");
    a_tx_latency: assert property (MSG_VALID && MSG_READY && !TX_VALID
        |=> TX_VALID && TX_DATA == $past(MSG_DATA))
        else $error("tx late");
    a_reset_quiet: assert property ($fell(RST) |-> !RX_DONE && !TX_VALID && MSG_READY)
        else $error("not idle");
endmodule // frame_check_assertions
bind modbus_crc_lrc_checker frame_check_assertions frame_check_assertions_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .RX_VALID(RX_VALID), .RX_EOF(RX_EOF),
    .RX_DONE(RX_DONE), .RX_ERR(RX_ERR), .MSG_VALID(MSG_VALID), .MSG_DATA(MSG_DATA),
    .MSG_LAST(MSG_LAST), .MSG_READY(MSG_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_READY(TX_READY)
);

// ---- test/line_partner.sv ----
// Line-side receiver that collects outgoing bytes and can stall
`timescale 1ns/1ps
module line_partner (
    input wire logic clk,
    input wire logic valid,
    input wire logic [7:0] data,
    input wire logic slow,
    output logic ready
);
    logic [1:0] cnt_r = 2'h0;
    logic ready_r = 1'b1;
    logic [7:0] got[$];
    assign ready = ready_r;
    // Slow mode takes one byte in four, enough to fill the buffer
    always @(posedge clk) begin
        if (valid && ready_r) begin
            got.push_back(data);
        end
        cnt_r <= cnt_r + 2'h1;
        ready_r <= !slow || cnt_r == 2'h2;
    end
endmodule // line_partner

// ---- test/testbench.sv ----
// Self-checking bench for the frame check block
`timescale 1ns/1ps
module testbench;
    typedef logic [7:0] bytes_t[$];
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ascii_mode = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_sof = 1'b0;
    logic rx_eof = 1'b0;
    logic msg_valid = 1'b0;
    logic [7:0] msg_data = 8'h00;
    logic msg_sof = 1'b0;
    logic msg_last = 1'b0;
    logic slow = 1'b0;
    logic rx_done, rx_err, msg_ready, tx_valid, tx_ready;
    logic [7:0] tx_data;
    int n_mismatch = 0;
    int tests_run = 0;
    always #2 sys_clk = ~sys_clk;
    modbus_crc_lrc_checker modbus_crc_lrc_checker_inst (.SYS_CLK(sys_clk), .RST(rst),
        .ASCII_MODE(ascii_mode), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_SOF(rx_sof),
        .RX_EOF(rx_eof), .RX_DONE(rx_done), .RX_ERR(rx_err), .MSG_VALID(msg_valid),
        .MSG_DATA(msg_data), .MSG_SOF(msg_sof), .MSG_LAST(msg_last), .MSG_READY(msg_ready),
        .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready));
    line_partner line_partner_inst (.clk(sys_clk), .valid(tx_valid), .data(tx_data),
        .slow(slow), .ready(tx_ready));
    function automatic bytes_t framed(bytes_t m, logic a);
        logic [15:0] c;
        logic [7:0] s;
        c = 16'hffff;
        s = 8'h00;
        foreach (m[i]) begin
            s += m[i];
            c ^= {8'h00, m[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        s = 8'hff - s + 8'h01;
        if (a) return {m, hexc(s[7:4]), hexc(s[3:0])};
        return {m, c[7:0], c[15:8]};
    endfunction
    function automatic logic [7:0] hexc(logic [3:0] h);
        return h < 4'ha ? 8'h30 + h : 8'h37 + h;
    endfunction
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Keep leaves valid up so the next frame starts with no gap
    task automatic rx_frame(bytes_t q, logic a, logic bad, logic keep);
        ascii_mode = a;
        foreach (q[i]) begin
            rx_valid = 1'b1;
            rx_data = q[i];
            rx_sof = i == 0;
            rx_eof = i == q.size() - 1;
            @(posedge sys_clk);
            #1;
        end
        check("rx done", rx_done, 1'b1);
        check("rx error", rx_err, bad);
        // An idle edge before the next frame raises valid again
        if (!keep) begin
            rx_valid = 1'b0;
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic tx_frame(bytes_t m, logic a, logic s);
        bytes_t exp;
        int k;
        exp = framed(m, a);
        slow = s;
        ascii_mode = a;
        line_partner_inst.got.delete();
        foreach (m[i]) begin
            msg_valid = 1'b1;
            msg_data = m[i];
            msg_sof = i == 0;
            msg_last = i == m.size() - 1;
            @(negedge sys_clk);
            for (k = 0; k < 50 && msg_ready !== 1'b1; k++) @(negedge sys_clk);
            @(posedge sys_clk);
            #1;
        end
        msg_valid = 1'b0;
        check("msg ready", msg_ready, 1'b0);
        for (k = 0; k < 200 && line_partner_inst.got.size() < exp.size(); k++)
            @(posedge sys_clk);
        #1;
        check("tx count", 16'(line_partner_inst.got.size()), 16'(exp.size()));
        foreach (exp[i]) check("tx byte", line_partner_inst.got[i], exp[i]);
    endtask
    task automatic test_rx_crc();
        rx_frame({8'h01, 8'h11, 8'hc0, 8'h2c}, 1'b0, 1'b0, 1'b1);
        rx_frame({8'h01, 8'h11, 8'h2c, 8'hc0}, 1'b0, 1'b1, 1'b1);
        rx_frame({8'h01, 8'h11, 8'hc0, 8'h2c}, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic test_rx_lrc();
        rx_frame({8'hff, 8'ha0, 8'h36, 8'h31}, 1'b1, 1'b0, 1'b0);
        rx_frame({8'hff, 8'ha0, 8'h31, 8'h36}, 1'b1, 1'b1, 1'b0);
        rx_frame({8'h05, 8'h46, 8'h42}, 1'b1, 1'b0, 1'b0);
        rx_frame({8'h05, 8'h46, 8'h62}, 1'b1, 1'b1, 1'b0);
        rx_frame({8'h01, 8'h02}, 1'b0, 1'b1, 1'b0);
    endtask
    task automatic test_tx_fast();
        tx_frame({8'h01, 8'h11}, 1'b0, 1'b0);
        tx_frame({8'hff, 8'ha0}, 1'b1, 1'b0);
    endtask
    // Identification reply, then a one-byte ASCII frame, pushed through a stalling line
    task automatic test_tx_id_slow();
        bytes_t r;
        r = {8'h01, 8'h11, 8'h1a};
        for (int i = 0; i < 26; i++) r.push_back(8'(i * 7));
        tx_frame(r, 1'b0, 1'b1);
        tx_frame({8'h05}, 1'b1, 1'b1);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        test_rx_crc();
        test_rx_lrc();
        test_tx_fast();
        test_tx_id_slow();
        give_verdict();
    end
    initial begin
        #40000;
        n_mismatch++;
        give_verdict();
    end
endmodule // testbench
